/* File: logic/lift_inspection_run_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lift_seq_consts.svh"
module lift_inspection_run_sequencer #(
  parameter int TICK_CYCLES = `TICK_PERIOD_US * `CLK_FREQ_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire lift_seq_pkg::reg_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic [`NUM_DI-1:0] di_pins,
  output lift_seq_pkg::drive_t drive,
  output logic [15:0] out_freq,
  output logic [15:0] carrier_khz,
  output logic insp_active,
  output logic torque_ramp
);

  logic [15:0] cfg_q [0:31];
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_prev_q;
  logic [`NUM_DI-1:0] di;
  logic [`NUM_DI-1:0] di_prev;
  lift_seq_pkg::fn_map_t fn_map;
  lift_seq_pkg::seq_state_t state_q;
  lift_seq_pkg::seq_state_t state_d;
  logic tick;
  logic [15:0] elapsed;
  logic dir;
  logic dir_prev;
  logic dir_rise;
  logic insp_in;
  logic insp_in_prev;
  logic digital_mode;
  logic stop_edge;
  logic no_ramp;
  logic insp_q;
  logic insp_sel;
  logic insp_n;
  logic [15:0] sel_speed;
  logic [15:0] target_q;
  logic [15:0] freq_q;
  logic [31:0] acc_q;
  logic [31:0] tick_add;
  logic [15:0] goal;
  logic [15:0] rtime;
  logic ramping;
  logic at_min;
  logic [15:0] hold_end;
  logic torque_variant;
  lift_seq_pkg::seq_state_t stop_to;

  // Power-on value of each configuration word
  function automatic logic [15:0] rst_value(input logic [4:0] idx);
    case (idx)
      `REG_INSP_SPEED: rst_value = `RST_INSP_SPEED;
      `REG_ZERO_SPEED: rst_value = `RST_ZERO_SPEED;
      `REG_START_HOLD: rst_value = `RST_START_HOLD;
      `REG_STOP_HOLD: rst_value = `RST_STOP_HOLD;
      `REG_BRAKE_OPEN: rst_value = `RST_BRAKE_OPEN;
      `REG_BRAKE_CLOSE: rst_value = `RST_BRAKE_CLOSE;
      `REG_RUN_DLY: rst_value = `RST_RUN_DLY;
      `REG_CONT_DLY: rst_value = `RST_CONT_DLY;
      `REG_TQ_RISE: rst_value = `RST_TQ_RISE;
      `REG_TQ_FADE: rst_value = `RST_TQ_FADE;
      `REG_CARRIER: rst_value = `RST_CARRIER;
      `REG_ACCEL: rst_value = `RST_ACCEL;
      default: rst_value = 16'h0000;
    endcase
  endfunction

  // True when any input mapped to code is active
  function automatic logic fn_active(
    input lift_seq_pkg::fn_map_t map,
    input logic [`NUM_DI-1:0] pins,
    input lift_seq_pkg::fn_code_t code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `NUM_DI; i++) begin
      if (map[i] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

  // Partial first millisecond never counts, so delays run late, never early
  function automatic logic ms_passed(input logic [15:0] since, input logic [15:0] delay);
    return since > delay;
  endfunction

  // Readback of one register word
  function automatic logic [31:0] read_word(input logic [4:0] addr,
                                            input logic [15:0] status,
                                            input logic [15:0] freq,
                                            input logic [15:0] cfg);
    if (addr == `REG_STATUS) begin
      read_word = {16'h0000, status};
    end else if (addr == `REG_OUT_FREQ) begin
      read_word = {16'h0000, freq};
    end else if (addr <= `REG_LAST) begin
      read_word = {16'h0000, cfg};
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction

  // Millisecond time base and the shared delay counter
  ms_tick_gen #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  ms_elapsed #(
    .W(16)
  ) u_elapsed (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .clr(state_d != state_q),
    .elapsed(elapsed)
  );

  // Configuration words; status and frequency are read-only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        cfg_q[i] <= rst_value(5'(i));
      end
    end else if (bus_req.we && bus_req.addr >= `REG_IN_FUNC0 &&
                 bus_req.addr <= `REG_LAST) begin
      cfg_q[bus_req.addr] <= bus_req.wdata[15:0];
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_req.re) begin
      bus_rdata <= read_word(bus_req.addr,
                             {state_q, 2'b00, torque_ramp, drive.dc_hold,
                              insp_active, drive.output_inhibit,
                              drive.contactor_close, drive.brake_open},
                             freq_q, cfg_q[bus_req.addr]);
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  // Two-stage pin synchronisers, then a history stage for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_prev_q <= 7'h00;
    end else begin
      pin_s1_q <= {up_pin, down_pin, di_pins};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Input function map and decoded commands
  always_comb begin
    for (int i = 0; i < `NUM_DI; i++) begin
      fn_map[i] = cfg_q[`REG_IN_FUNC0 + i][6:0];
    end
  end

  assign di = pin_s2_q[`NUM_DI-1:0];
  assign di_prev = pin_prev_q[`NUM_DI-1:0];
  assign dir = pin_s2_q[6] | pin_s2_q[5];
  assign dir_prev = pin_prev_q[6] | pin_prev_q[5];
  assign dir_rise = dir & ~dir_prev;
  assign digital_mode = fn_active(fn_map, '1, `FN_INSPECTION);
  assign insp_in = fn_active(fn_map, di, `FN_INSPECTION);
  assign insp_in_prev = fn_active(fn_map, di_prev, `FN_INSPECTION);
  assign torque_variant = (cfg_q[`REG_ANALOG_FN] == `ANALOG_FN_TORQUE);
  assign no_ramp = (cfg_q[`REG_INSP_DECEL] == 16'h0000);

  // Speed selection; leveling outranks the others
  always_comb begin
    if (fn_active(fn_map, di, `FN_LEVELING)) begin
      sel_speed = cfg_q[`REG_SPD_LEVELING];
    end else if (fn_active(fn_map, di, `FN_RELEVEL)) begin
      sel_speed = cfg_q[`REG_SPD_RELEVEL];
    end else if (fn_active(fn_map, di, `FN_INTERMED)) begin
      sel_speed = cfg_q[`REG_SPD_INTERMED];
    end else if (fn_active(fn_map, di, `FN_NOMINAL)) begin
      sel_speed = cfg_q[`REG_SPD_NOMINAL];
    end else begin
      sel_speed = 16'h0000;
    end
  end

  // Inspection decision, sampled when the direction arrives
  always_comb begin
    if (digital_mode) begin
      insp_sel = insp_in;
    end else begin
      insp_sel = (sel_speed >= cfg_q[`REG_INSP_LOWER]) &&
                 (sel_speed <= cfg_q[`REG_INSP_UPPER]);
    end
    insp_n = (state_q == lift_seq_pkg::ST_IDLE) ? insp_sel : insp_q;
  end

  // Either command falling ends the run
  assign stop_edge = (dir_prev & ~dir) |
                     (insp_q & digital_mode & insp_in_prev & ~insp_in);
  assign stop_to = (insp_q && no_ramp) ? lift_seq_pkg::ST_IDLE
                                       : lift_seq_pkg::ST_DECEL;
  assign at_min = (freq_q <= cfg_q[`REG_ZERO_SPEED]);

  // Start hold covers brake delay and, if used, torque rise
  always_comb begin
    hold_end = max16(cfg_q[`REG_START_HOLD], cfg_q[`REG_BRAKE_OPEN]);
    if (torque_variant) begin
      hold_end = max16(hold_end, cfg_q[`REG_TQ_RISE]);
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lift_seq_pkg::ST_IDLE: begin
        if (dir_rise) begin
          state_d = lift_seq_pkg::ST_CONTACT;
        end
      end
      lift_seq_pkg::ST_CONTACT: begin
        if (stop_edge) begin
          state_d = stop_to;
        end else if (fn_active(fn_map, '1, `FN_CONTACTOR_OK)
                     ? fn_active(fn_map, di, `FN_CONTACTOR_OK)
                     : ms_passed(elapsed, cfg_q[`REG_RUN_DLY])) begin
          state_d = lift_seq_pkg::ST_START_HOLD;
        end
      end
      lift_seq_pkg::ST_START_HOLD: begin
        if (stop_edge) begin
          state_d = stop_to;
        end else if (ms_passed(elapsed, hold_end)) begin
          state_d = lift_seq_pkg::ST_RUN;
        end
      end
      lift_seq_pkg::ST_RUN: begin
        if (stop_edge) begin
          state_d = stop_to;
        end
      end
      lift_seq_pkg::ST_DECEL: begin
        if (at_min) begin
          state_d = insp_q ? lift_seq_pkg::ST_CUT
                           : lift_seq_pkg::ST_STOP_HOLD;
        end
      end
      lift_seq_pkg::ST_STOP_HOLD: begin
        if (ms_passed(elapsed, max16(cfg_q[`REG_STOP_HOLD], cfg_q[`REG_BRAKE_CLOSE]))) begin
          state_d = lift_seq_pkg::ST_CONT_OPEN;
        end
      end
      lift_seq_pkg::ST_CUT: begin
        state_d = lift_seq_pkg::ST_IDLE;
      end
      lift_seq_pkg::ST_CONT_OPEN: begin
        if (ms_passed(elapsed, cfg_q[`REG_CONT_DLY])) begin
          state_d = lift_seq_pkg::ST_IDLE;
        end
      end
      default: state_d = lift_seq_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= lift_seq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Run kind and target speed latched at start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      insp_q <= 1'b0;
      target_q <= 16'h0000;
    end else if (state_q == lift_seq_pkg::ST_IDLE && dir_rise) begin
      insp_q <= insp_sel;
      target_q <= (digital_mode && insp_in) ? cfg_q[`REG_INSP_SPEED]
                                            : sel_speed;
    end
  end

  // Ramp goal and rate; inspection decel uses its own time
  assign ramping = (state_q == lift_seq_pkg::ST_RUN) ||
                   (state_q == lift_seq_pkg::ST_DECEL);
  assign goal = (state_q == lift_seq_pkg::ST_RUN) ? target_q : 16'h0000;
  assign rtime = (state_q == lift_seq_pkg::ST_DECEL && insp_q)
                 ? cfg_q[`REG_INSP_DECEL] : cfg_q[`REG_ACCEL];
  assign tick_add = tick ? {16'h0000, target_q} : 32'h0000_0000;

  // Bresenham stepping: a full swing of target takes rtime ms.
  // One step per clock is far faster than any ms-scale slope needs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_q <= 16'h0000;
      acc_q <= 32'h0000_0000;
    end else if (!ramping) begin
      acc_q <= 32'h0000_0000;
      if (state_q != lift_seq_pkg::ST_STOP_HOLD) begin
        freq_q <= 16'h0000;
      end
    end else if (rtime == 16'h0000) begin
      freq_q <= goal;
      acc_q <= 32'h0000_0000;
    end else if (freq_q == goal) begin
      acc_q <= 32'h0000_0000;
    end else if (acc_q >= {16'h0000, rtime}) begin
      acc_q <= acc_q - {16'h0000, rtime} + tick_add;
      freq_q <= (freq_q < goal) ? freq_q + 16'h0001 : freq_q - 16'h0001;
    end else begin
      acc_q <= acc_q + tick_add;
    end
  end

  // Contactor, inhibit and hold follow the next state directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive.contactor_close <= 1'b0;
      drive.output_inhibit <= 1'b1;
      drive.dc_hold <= 1'b0;
    end else begin
      drive.contactor_close <= !(state_d inside {lift_seq_pkg::ST_IDLE,
                                                 lift_seq_pkg::ST_CUT});
      drive.output_inhibit <= state_d inside {lift_seq_pkg::ST_IDLE,
                                              lift_seq_pkg::ST_CONTACT,
                                              lift_seq_pkg::ST_CONT_OPEN};
      drive.dc_hold <= state_d inside {lift_seq_pkg::ST_START_HOLD,
                                       lift_seq_pkg::ST_STOP_HOLD};
    end
  end

  // Brake opens late in start hold; closes late in stop hold, or at once when an inspection run cuts to ST_CUT or ST_IDLE
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive.brake_open <= 1'b0;
    end else if (state_d inside {lift_seq_pkg::ST_IDLE, lift_seq_pkg::ST_CONTACT,
                                 lift_seq_pkg::ST_CUT,
                                 lift_seq_pkg::ST_CONT_OPEN}) begin
      drive.brake_open <= 1'b0;
    end else if (state_q == lift_seq_pkg::ST_START_HOLD &&
                 ms_passed(elapsed, cfg_q[`REG_BRAKE_OPEN])) begin
      drive.brake_open <= 1'b1;
    end else if (state_q == lift_seq_pkg::ST_STOP_HOLD &&
                 ms_passed(elapsed, cfg_q[`REG_BRAKE_CLOSE])) begin
      drive.brake_open <= 1'b0;
    end
  end

  // Mode outputs; low carrier cuts motor noise during inspection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      insp_active <= 1'b0;
      carrier_khz <= `RST_CARRIER;
      torque_ramp <= 1'b0;
      out_freq <= 16'h0000;
    end else begin
      insp_active <= (state_d != lift_seq_pkg::ST_IDLE) && insp_n;
      carrier_khz <= ((state_d != lift_seq_pkg::ST_IDLE) && insp_n)
                     ? `CARRIER_INSP_KHZ : cfg_q[`REG_CARRIER];
      torque_ramp <= torque_variant &&
                     (state_d == lift_seq_pkg::ST_START_HOLD);
      out_freq <= freq_q;
    end
  end

endmodule // lift_inspection_run_sequencer
`default_nettype wire

/* File: logic/lift_seq_consts.svh */
`ifndef LIFT_SEQ_CONSTS_SVH
`define LIFT_SEQ_CONSTS_SVH

// Register word indexes
`define REG_STATUS 5'h00
`define REG_OUT_FREQ 5'h01
`define REG_IN_FUNC0 5'h02
`define REG_INSP_SPEED 5'h07
`define REG_INSP_DECEL 5'h08
`define REG_INSP_LOWER 5'h09
`define REG_INSP_UPPER 5'h0A
`define REG_ZERO_SPEED 5'h0B
`define REG_START_HOLD 5'h0C
`define REG_STOP_HOLD 5'h0D
`define REG_BRAKE_OPEN 5'h0E
`define REG_BRAKE_CLOSE 5'h0F
`define REG_RUN_DLY 5'h10
`define REG_CONT_DLY 5'h11
`define REG_TQ_RISE 5'h12
`define REG_TQ_FADE 5'h13
`define REG_ANALOG_FN 5'h14
`define REG_CARRIER 5'h15
`define REG_ACCEL 5'h16
`define REG_SPD_NOMINAL 5'h17
`define REG_SPD_INTERMED 5'h18
`define REG_SPD_RELEVEL 5'h19
`define REG_SPD_LEVELING 5'h1A
`define REG_LAST 5'h1A

// Multi-function input codes (80..84, 86)
`define NUM_DI 5
`define FN_NOMINAL 7'h50
`define FN_INTERMED 7'h51
`define FN_RELEVEL 7'h52
`define FN_LEVELING 7'h53
`define FN_INSPECTION 7'h54
`define FN_CONTACTOR_OK 7'h56

// Reset values: times in ms, speeds in 0.01 Hz
`define RST_INSP_SPEED 16'h09C4
`define RST_ZERO_SPEED 16'h0032
`define RST_START_HOLD 16'h0190
`define RST_STOP_HOLD 16'h0258
`define RST_BRAKE_OPEN 16'h00C8
`define RST_BRAKE_CLOSE 16'h0064
`define RST_RUN_DLY 16'h0064
`define RST_CONT_DLY 16'h0064
`define RST_TQ_RISE 16'h01F4
`define RST_TQ_FADE 16'h03E8
`define RST_CARRIER 16'h0008
`define RST_ACCEL 16'h07D0
`define CARRIER_INSP_KHZ 16'h0002
`define ANALOG_FN_TORQUE 16'h0001

// Timing base
`define TICK_PERIOD_US 1000
`define CLK_FREQ_MHZ 100

// Status word bit positions
`define ST_BRAKE 0
`define ST_CONTACTOR 1
`define ST_INHIBIT 2
`define ST_INSP 3
`define ST_HOLD 4
`define ST_TORQUE 5
`define ST_STATE_LSB 8

`endif

/* File: logic/lift_seq_pkg.sv */
`include "lift_seq_consts.svh"
package lift_seq_pkg;

  // One-hot sequence states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CONTACT = 8'h02,
    ST_START_HOLD = 8'h04,
    ST_RUN = 8'h08,
    ST_DECEL = 8'h10,
    ST_STOP_HOLD = 8'h20,
    ST_CUT = 8'h40,
    ST_CONT_OPEN = 8'h80
  } seq_state_t;

  typedef logic [6:0] fn_code_t;
  typedef fn_code_t [`NUM_DI-1:0] fn_map_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } reg_req_t;

  typedef struct packed {
    logic brake_open;
    logic contactor_close;
    logic output_inhibit;
    logic dc_hold;
  } drive_t;

endpackage

/* File: logic/ms_elapsed.sv */
`timescale 1ns/1ps
`default_nettype none
// Milliseconds since the last clear, saturating so long waits never wrap
module ms_elapsed #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic clr,
  output logic [W-1:0] elapsed
);
  // Clear wins over a tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed <= '0;
    end else if (clr) begin
      elapsed <= '0;
    end else if (tick && elapsed != '1) begin
      elapsed <= elapsed + W'(1);
    end
  end
endmodule // ms_elapsed
`default_nettype wire

/* File: logic/ms_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock down to a one-cycle millisecond enable
module ms_tick_gen #(
  parameter int PERIOD = 100000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] cnt_q;

  // Free-running count, pulse on wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
    end
  end
endmodule // ms_tick_gen
`default_nettype wire

/* File: testbench/lift_controller_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Lift controller side: selection first, direction later, release after stop
module lift_controller_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic by_insp,
  input wire logic insp_req,
  input wire logic dn,
  input wire logic [3:0] spd,
  output logic up_pin,
  output logic down_pin,
  output logic [4:0] di_pins
);
  logic [3:0] cnt_q;
  logic run_q;

  // Settle time before direction avoids a run with a stale selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      up_pin <= 1'b0;
      down_pin <= 1'b0;
      di_pins <= 5'h00;
    end else if (go && !run_q) begin
      di_pins <= {spd, insp_req};
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hE) begin
        run_q <= 1'b1;
        up_pin <= !dn;
        down_pin <= dn;
      end
    end else if (run_q && go) begin
      di_pins[4:1] <= spd;
    end else if (run_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (by_insp) begin
        di_pins[0] <= 1'b0;
      end else begin
        up_pin <= 1'b0;
        down_pin <= 1'b0;
      end
      if (cnt_q == 4'h1) begin
        run_q <= 1'b0;
        up_pin <= 1'b0;
        down_pin <= 1'b0;
        di_pins <= 5'h00;
      end
    end
  end
endmodule // lift_controller_model
`default_nettype wire

/* File: testbench/lift_inspection_run_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lift_inspection_run_sequencer_tb_top;
  typedef struct packed {logic [4:0] a; logic [15:0] v;} row_t;
  logic clk;
  logic rst;
  lift_seq_pkg::reg_req_t bus_req;
  logic [31:0] bus_rdata;
  logic up_pin;
  logic down_pin;
  logic [4:0] di_pins;
  lift_seq_pkg::drive_t drive;
  logic [15:0] out_freq;
  logic [15:0] carrier_khz;
  logic insp_active;
  logic torque_ramp;
  logic go;
  logic by_insp;
  logic insp_req;
  logic dn;
  logic [3:0] spd;
  logic [31:0] rd;
  int bad_count;
  int checks_done;
  int n;
  // Reset values: address, expected word
  row_t rows [15] = '{'{5'h00, 16'h0104}, '{5'h01, 16'h0000}, '{5'h02, 16'h0000},
    '{5'h07, 16'h09C4}, '{5'h08, 16'h0000}, '{5'h0A, 16'h0000}, '{5'h0C, 16'h0190},
    '{5'h0D, 16'h0258}, '{5'h0E, 16'h00C8}, '{5'h0F, 16'h0064}, '{5'h10, 16'h0064},
    '{5'h11, 16'h0064}, '{5'h12, 16'h01F4}, '{5'h13, 16'h03E8}, '{5'h1F, 16'h0000}};
  // Window bounds: lower, upper, inspection expected
  logic [32:0] cmp [3] = '{{16'h0100, 16'h0100, 1'b1}, {16'h0101, 16'h0200, 1'b0},
    {16'h0080, 16'h00FF, 1'b0}};

  lift_inspection_run_sequencer #(.TICK_CYCLES(10)) lift_inspection_run_sequencer_i (
    .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .up_pin(up_pin),
    .down_pin(down_pin), .di_pins(di_pins), .drive(drive), .out_freq(out_freq),
    .carrier_khz(carrier_khz), .insp_active(insp_active), .torque_ramp(torque_ramp));
  lift_controller_model lift_controller_model_i (.clk(clk), .rst(rst), .go(go),
    .by_insp(by_insp), .insp_req(insp_req), .dn(dn), .spd(spd), .up_pin(up_pin),
    .down_pin(down_pin), .di_pins(di_pins));

  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Idle edge first so two back-to-back calls never clash in one step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{a, {16'h0000, d}, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.we <= 1'b0;
  endtask

  task automatic rdw(input logic [4:0] a);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.re <= 1'b0;
    @(posedge clk);
    rd = bus_rdata;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return drive.dc_hold;
      1: return drive.brake_open;
      2: return drive.output_inhibit;
      3: return drive.contactor_close;
      4: return out_freq == 16'h0100;
      default: return torque_ramp;
    endcase
  endfunction

  // Bounded wait, n holds the edges spent
  task automatic wait_on(input int s, input logic lvl);
    n = 0;
    while (pick(s) !== lvl && n < 30000) begin
      @(posedge clk);
      n++;
    end
    // A wait that runs out is a mismatch, not a silent pass
    if (pick(s) !== lvl) begin
      bad_count++;
      $display("BAD wait %0d expected %0d seen %0d", s, lvl, pick(s));
    end
  endtask

  task automatic start(input logic ins, input logic d, input logic [3:0] s);
    @(posedge clk);
    insp_req <= ins;
    dn <= d;
    spd <= s;
    go <= 1'b1;
  endtask

  task automatic halt(input logic bi);
    @(posedge clk);
    by_insp <= bi;
    go <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog sized well past the longest run
  initial begin
    #900000;
    bad_count++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    bus_req = '0;
    {go, by_insp, insp_req, dn, spd} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_w("reset drive", 32'h2, drive);
    chk_w("reset carrier", 32'h8, carrier_khz);
    wr(5'h00, 16'hFFFF);
    wr(5'h1F, 16'hFFFF);
    foreach (rows[i]) begin
      rdw(rows[i].a);
      chk_w("reg reset", {16'h0, rows[i].v}, rd);
    end
    // Short timings keep the runs brief
    wr(5'h10, 16'h0002);
    wr(5'h0C, 16'h0004);
    wr(5'h0E, 16'h0002);
    wr(5'h0D, 16'h0002);
    wr(5'h0F, 16'h0002);
    wr(5'h11, 16'h0002);
    wr(5'h16, 16'h000A);
    wr(5'h07, 16'h0100);
    // Digital selection, stop without ramp
    wr(5'h02, 16'h0054);
    start(1'b1, 1'b0, 4'h0);
    wait_on(0, 1'b1);
    wait_on(1, 1'b1);
    chk_w("brake delay", 1, n >= 19 && n <= 33);
    wait_on(4, 1'b1);
    chk_w("insp speed", 32'h0100, out_freq);
    chk_w("insp flag", 1, insp_active);
    chk_w("carrier", 32'h2, carrier_khz);
    halt(1'b1);
    wait_on(2, 1'b1);
    chk_w("cut latency", 1, n <= 7);
    chk_w("cut brake", 0, drive.brake_open);
    chk_w("cut contactor", 0, drive.contactor_close);
    repeat (40) @(posedge clk);
    // Ramp stop by direction removal, down travel
    wr(5'h08, 16'h000A);
    start(1'b1, 1'b1, 4'h0);
    wait_on(4, 1'b1);
    halt(1'b0);
    wait_on(1, 1'b0);
    chk_w("ramp length", 1, n > 8);
    chk_w("min freq", 1, out_freq <= 16'h0032);
    chk_w("ramp contactor", 0, drive.contactor_close);
    chk_w("early inhibit", 0, drive.output_inhibit);
    wait_on(2, 1'b1);
    chk_w("late inhibit", 1, n <= 2);
    repeat (40) @(posedge clk);
    // Speed window detection, selection by nominal input
    wr(5'h02, 16'h0000);
    wr(5'h03, 16'h0050);
    wr(5'h17, 16'h0100);
    wr(5'h08, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(5'h09, cmp[i][32:17]);
      wr(5'h0A, cmp[i][16:1]);
      start(1'b0, 1'b0, 4'h1);
      wait_on(0, 1'b1);
      chk_w("window", cmp[i][0], insp_active);
      chk_w("window carrier", cmp[i][0] ? 32'h2 : 32'h8, carrier_khz);
      halt(1'b0);
      wait_on(3, 1'b0);
      repeat (40) @(posedge clk);
    end
    // Confirmation input and torque variant on a normal run
    wr(5'h04, 16'h0056);
    wr(5'h14, 16'h0001);
    start(1'b0, 1'b0, 4'h1);
    wait_on(3, 1'b1);
    repeat (60) @(posedge clk);
    chk_w("hold before confirm", 0, drive.dc_hold);
    spd <= 4'h3;
    wait_on(0, 1'b1);
    chk_w("confirm latency", 1, n <= 8);
    wait_on(5, 1'b1);
    chk_w("torque start", 1, n <= 3);
    wait_on(1, 1'b1);
    halt(1'b0);
    wait_on(2, 1'b1);
    wait_on(3, 1'b0);
    chk_w("contactor delay", 1, n >= 19 && n <= 33);
    test_done();
  end
endmodule // lift_inspection_run_sequencer_tb_top
`default_nettype wire

/* File: testbench/lift_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the sequencer ports only
module lift_seq_properties (
  input wire logic clk,
  input wire logic rst,
  input wire lift_seq_pkg::reg_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic [4:0] di_pins,
  input wire lift_seq_pkg::drive_t drive,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] carrier_khz,
  input wire logic insp_active,
  input wire logic torque_ramp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Output interlocks
  chk_brake_contact: assert property (drive.brake_open |-> drive.contactor_close)
    else $error("brake open while contactor is off");
  chk_brake_inhibit: assert property (drive.brake_open |-> !drive.output_inhibit)
    else $error("brake open while output is cut");
  chk_brake_in_hold: assert property ($rose(drive.brake_open) |-> drive.dc_hold)
    else $error("brake opened outside the start hold");
  chk_insp_drop: assert property ($fell(drive.brake_open) && $past(insp_active)
    |-> $fell(drive.contactor_close))
    else $error("brake and contactor did not drop together");
  // Carrier forced low once inspection has settled for a cycle
  chk_carrier_insp: assert property (insp_active && $past(insp_active)
    |-> carrier_khz == 16'h0002)
    else $error("carrier not reduced during inspection");
  chk_torque_hold: assert property (torque_ramp |-> drive.dc_hold)
    else $error("torque ramp outside start hold");
  // Pin edge needs two sync flops, then one register; the history flop adds no delay
  chk_start_delay: assert property ($rose(drive.contactor_close)
    |-> $past(up_pin || down_pin, 3))
    else $error("contactor closed without a direction command");
  // Read data stands only in the cycle after the strobe
  chk_rdata_quiet: assert property (!$past(bus_req.re) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_rdata_upper: assert property ($past(bus_req.re) |-> bus_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");

  cover property ($fell(drive.brake_open) && insp_active);
  cover property ($rose(insp_active));
  cover property ($rose(torque_ramp));
endmodule // lift_seq_properties

bind lift_inspection_run_sequencer lift_seq_properties lift_seq_properties_i (
  .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .up_pin(up_pin),
  .down_pin(down_pin), .di_pins(di_pins), .drive(drive), .out_freq(out_freq),
  .carrier_khz(carrier_khz), .insp_active(insp_active), .torque_ramp(torque_ramp));
`default_nettype wire
